// File: hw/rsmc_pkg.sv
/*
 Package for the rail sleep/mode control register slice: offsets, fields, reset values, carriers.
 Assumes a byte-wide register port driven by the serial host front end of the device.
*/
package rsmc_pkg;
    // Register offsets
    localparam logic [7:0] RSMC_OFS_RAIL3_VOLT = 8'h23;
    localparam logic [7:0] RSMC_OFS_RAIL3_SLEEP = 8'h24;
    localparam logic [7:0] RSMC_OFS_RAIL4_CTRL = 8'h25;
    localparam logic [7:0] RSMC_OFS_RAIL5_CTRL = 8'h26;
    localparam logic [7:0] RSMC_OFS_RAIL6_CTRL = 8'h27;
    localparam logic [7:0] RSMC_OFS_LREG2_CTRL = 8'h28;
    // Field positions
    localparam int RSMC_CODE_MSB = 7;
    localparam int RSMC_CODE_LSB = 1;
    localparam int RSMC_SLEEP_EN_BIT = 0;
    localparam int RSMC_MODE_BIT = 1;
    localparam int RSMC_OFF_BIT = 0;
    localparam int RSMC_KEEP_MSB = 5;
    localparam int RSMC_KEEP_LSB = 2;
    // Fixed values of the control registers
    localparam logic [3:0] RSMC_KEEP_RST = 4'hf;
    localparam logic [1:0] RSMC_RO_VAL = 2'h0;
    // Step sizes of the two code ranges, in mV
    localparam int RSMC_STEP_FINE_MV = 10;
    localparam int RSMC_STEP_COARSE_MV = 25;
    // Mode select encoding
    localparam logic RSMC_MODE_AUTO = 1'b0;
    localparam logic RSMC_MODE_PWM = 1'b1;

    // Host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsmc_req_type;

    // Factory programmed reset images
    typedef struct packed {
        logic [7:0] rail3_volt;
        logic [7:0] rail3_sleep;
        logic [7:0] rail4;
        logic [7:0] rail5;
        logic [7:0] rail6;
        logic [7:0] lreg2;
        logic sleep_by_pin_a;
        logic sleep_by_pin_b;
    } rsmc_otp_type;

    // Per-rail control outputs
    typedef struct packed {
        logic [6:0] rail3_voltage_code;
        logic rail3_in_sleep;
        logic [2:0] mode_pwm;
        logic [3:0] rail_allowed;
    } rsmc_ctrl_type;
endpackage

// File: hw/rsmc_code_scale.sv
/*
 Converts a 7-bit voltage code to its step offset in mV for the selected range.
 Assumes the analogue side adds the range base voltage.
*/
`timescale 1ns/10ps
`default_nettype none
module rsmc_code_scale (
    input wire logic [6:0] code_i, // Voltage code
    input wire logic coarse_i, // 1 selects the 25 mV range
    output logic [11:0] step_mv_o // Offset above range base
);
    import rsmc_pkg::*;
    // Code times step size of the configured range
    always_comb begin
        if (coarse_i) begin
            step_mv_o = 12'(int'(code_i) * RSMC_STEP_COARSE_MV);
        end else begin
            step_mv_o = 12'(int'(code_i) * RSMC_STEP_FINE_MV);
        end
    end
endmodule
`default_nettype wire

// File: hw/rsmc_regs.sv
/*
 Register slice at 23h..28h: rail-three normal and sleep codes, mode and off controls.
 Assumes the serial front end presents one-cycle read or write strobes, synchronous to clk_i,
 and that the factory image is stable while srst_i is high.
*/
`timescale 1ns/10ps
`default_nettype none
module rsmc_regs (
    input wire logic clk_i, // 40 MHz clock
    input wire logic srst_i, // Synchronous reset, active high
    input wire rsmc_pkg::rsmc_req_type req_i, // Host read/write strobe
    input wire rsmc_pkg::rsmc_otp_type otp_i, // Factory reset image
    input wire logic sleep_pin_a_i, // Sleep control input A
    input wire logic sleep_pin_b_i, // Sleep control input B
    input wire logic rail3_coarse_i, // Rail-three 25 mV range selected
    output logic [7:0] rdata_o, // Read data
    output logic rvalid_o, // Read data valid pulse
    output rsmc_pkg::rsmc_ctrl_type ctrl_o, // Rail controls
    output logic [11:0] rail3_step_mv_o // Rail-three target offset in mV
);
    import rsmc_pkg::*;

    // Register map of this slice:
    //   23h bits 7:1 rail-three normal code, bit 0 spare
    //   24h bits 7:1 rail-three sleep code, bit 0 sleep enable
    //   25h to 27h rails four to six, bit 1 mode, bit 0 off override
    //   28h linear regulator two, bit 0 off override
    //   25h to 28h bits 7:6 read as zero, bits 5:2 kept set by the host
    //   Other offsets read as zero and ignore writes
    // A write lands at its strobe edge and shows on ctrl_o one edge later;
    // a read answers at its strobe edge.

    // Register storage
    logic [7:0] rail3_volt_ff;
    logic [7:0] rail3_sleep_ff;
    logic [7:0] ctrl_ff [4]; // Rails four, five, six, linear two

    // Sleep tracking
    logic sleep_ff;
    logic rst_seen_ff;
    logic sleep_req;
    logic sleep_entry;

    // Host decode
    logic [2:0] addr_idx;
    logic wr_volt;
    logic wr_sleep;
    logic wr_ctrl;

    // Datapath
    logic [11:0] step_mv;
    logic [7:0] nxt_rdata;

    // Write image of a control register: read-only bits stay fixed
    function automatic logic [7:0] ctrl_wr(input logic [7:0] d);
        return {RSMC_RO_VAL, d[RSMC_KEEP_MSB:0]};
    endfunction

    // Reset image of a control register: factory bits 1:0, bits 5:2 set
    function automatic logic [7:0] ctrl_rst(input logic [7:0] otp);
        return {RSMC_RO_VAL, RSMC_KEEP_RST, otp[RSMC_MODE_BIT:RSMC_OFF_BIT]};
    endfunction

    // Voltage code field of a rail-three register
    function automatic logic [6:0] code_of(input logic [7:0] r);
        return r[RSMC_CODE_MSB:RSMC_CODE_LSB];
    endfunction

    // Index of a control register or 3'h7 if none
    function automatic logic [2:0] ctrl_idx(input logic [7:0] a);
        unique case (a)
            RSMC_OFS_RAIL4_CTRL: ctrl_idx = 3'h0;
            RSMC_OFS_RAIL5_CTRL: ctrl_idx = 3'h1;
            RSMC_OFS_RAIL6_CTRL: ctrl_idx = 3'h2;
            RSMC_OFS_LREG2_CTRL: ctrl_idx = 3'h3;
            default: ctrl_idx = 3'h7;
        endcase
    endfunction

    // Host write strobes, one per register group
    assign addr_idx = ctrl_idx(req_i.addr);
    assign wr_volt = req_i.wr && req_i.addr == RSMC_OFS_RAIL3_VOLT;
    assign wr_sleep = req_i.wr && req_i.addr == RSMC_OFS_RAIL3_SLEEP;
    assign wr_ctrl = req_i.wr && addr_idx != 3'h7;

    // Sleep request: enable bit gated by factory routing of a sleep pin.
    // Without routing the enable bit is inert, whatever the pins do.
    assign sleep_req = rail3_sleep_ff[RSMC_SLEEP_EN_BIT]
        && ((otp_i.sleep_by_pin_a && sleep_pin_a_i)
        || (otp_i.sleep_by_pin_b && sleep_pin_b_i));
    // Entry is the rising edge of the request; the first cycle after reset
    // is masked, so a request already standing at reset is not an entry.
    assign sleep_entry = sleep_req && !sleep_ff && rst_seen_ff;

    // Previous sleep request, for edge detection
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sleep_ff <= 1'b0;
        end else begin
            sleep_ff <= sleep_req;
        end
    end

    // Marks that the first cycle after reset has passed
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rst_seen_ff <= 1'b0;
        end else begin
            rst_seen_ff <= 1'b1;
        end
    end

    // Rail-three normal code. The sleep entry copy beats a host write in the
    // same cycle, so the rail keeps the sleep target it has just entered.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rail3_volt_ff <= otp_i.rail3_volt;
        end else if (sleep_entry) begin
            rail3_volt_ff[RSMC_CODE_MSB:RSMC_CODE_LSB] <=
                code_of(rail3_sleep_ff);
        end else if (wr_volt) begin
            rail3_volt_ff <= req_i.wdata;
        end
    end

    // Rail-three sleep code and enable; the code reaches the rail only
    // through the entry copy into the normal code
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rail3_sleep_ff <= otp_i.rail3_sleep;
        end else if (wr_sleep) begin
            rail3_sleep_ff <= req_i.wdata;
        end
    end

    // Control registers of rails four to six and linear regulator two.
    // Bits 5:2 reset to ones; the host is trusted to keep them set.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_ff[0] <= ctrl_rst(otp_i.rail4);
            ctrl_ff[1] <= ctrl_rst(otp_i.rail5);
            ctrl_ff[2] <= ctrl_rst(otp_i.rail6);
            ctrl_ff[3] <= ctrl_rst(otp_i.lreg2);
        end else if (wr_ctrl) begin
            ctrl_ff[addr_idx[1:0]] <= ctrl_wr(req_i.wdata);
        end
    end

    // Read mux over the current register contents;
    // offsets outside the slice read as zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (req_i.addr == RSMC_OFS_RAIL3_VOLT) begin
            nxt_rdata = rail3_volt_ff;
        end else if (req_i.addr == RSMC_OFS_RAIL3_SLEEP) begin
            nxt_rdata = rail3_sleep_ff;
        end else if (addr_idx != 3'h7) begin
            nxt_rdata = ctrl_ff[addr_idx[1:0]];
        end
    end

    // Read valid pulse, one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.rd;
        end
    end

    // Read data, held until the next read
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            rdata_o <= nxt_rdata;
        end
    end

    // Step offset of the active rail-three code; the range pin is taken
    // as it stands, the analogue side adds the range base
    rsmc_code_scale u_scale (
        .code_i(code_of(rail3_volt_ff)),
        .coarse_i(rail3_coarse_i),
        .step_mv_o(step_mv)
    );

    // Registered rail controls. Mode and off bits pass through unchanged;
    // rail_allowed low means the rail is forced off.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_o <= '0;
            rail3_step_mv_o <= 12'h000;
        end else begin
            rail3_step_mv_o <= step_mv;
            ctrl_o.rail3_voltage_code <= code_of(rail3_volt_ff);
            ctrl_o.rail3_in_sleep <= sleep_ff;
            for (int i = 0; i < 3; i++) begin
                ctrl_o.mode_pwm[i] <= ctrl_ff[i][RSMC_MODE_BIT] == RSMC_MODE_PWM;
            end
            for (int i = 0; i < 4; i++) begin
                ctrl_o.rail_allowed[i] <= ctrl_ff[i][RSMC_OFF_BIT];
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/rsmc_regs_monitor.sv
/*
 Checker of the register slice ports.
 Assumes one-cycle strobes and a host that keeps bits 5:2 set.
*/
`timescale 1ns/10ps
`default_nettype none
module rsmc_regs_monitor
    import rsmc_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic srst_i, // Reset
    input wire rsmc_pkg::rsmc_req_type req_i, // Request
    input wire rsmc_pkg::rsmc_otp_type otp_i, // Image
    input wire logic sleep_pin_a_i, // Pin A
    input wire logic sleep_pin_b_i, // Pin B
    input wire logic rail3_coarse_i, // Range
    input wire logic [7:0] rdata_o, // Read data
    input wire logic rvalid_o, // Read pulse
    input wire rsmc_pkg::rsmc_ctrl_type ctrl_o, // Controls
    input wire logic [11:0] rail3_step_mv_o // Step
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Host strobes
    sequence s_ctrl_rd;
        req_i.rd && req_i.addr inside {[8'h25:8'h28]};
    endsequence
    sequence s_wr(logic [7:0] a);
        req_i.wr && req_i.addr == a;
    endsequence
    a_read_pulse: assert property (rvalid_o == $past(req_i.rd))
        else $error("read pulse wrong");
    a_ro_zero: assert property (s_ctrl_rd |=> rdata_o[7:6] == 2'h0)
        else $error("read-only bits set");
    a_keep_set: assert property (s_ctrl_rd |=> rdata_o[5:2] == 4'hf)
        else $error("kept bits lost");
    a_mode_wr: assert property (s_wr(8'h25) |-> ##2 ctrl_o.mode_pwm[0] == $past(req_i.wdata[1], 2))
        else $error("mode not applied");
    a_rail_off: assert property (s_wr(8'h25) |-> ##2 ctrl_o.rail_allowed[0] == $past(req_i.wdata[0], 2))
        else $error("rail off not applied");
    a_lreg_off: assert property (s_wr(8'h28) |-> ##2 ctrl_o.rail_allowed[3] == $past(req_i.wdata[0], 2))
        else $error("regulator off not applied");
    a_sleep_gate: assert property (ctrl_o.rail3_in_sleep |-> $past((otp_i.sleep_by_pin_a && sleep_pin_a_i) || (otp_i.sleep_by_pin_b && sleep_pin_b_i), 2))
        else $error("sleep without routed pin");
    a_copy_once: assert property (ctrl_o.rail3_in_sleep && $past(ctrl_o.rail3_in_sleep) && !$past(req_i.wr, 2) |-> $stable(ctrl_o.rail3_voltage_code))
        else $error("code changed in sleep");
    a_step_scale: assert property (($stable(ctrl_o.rail3_voltage_code) && $stable(rail3_coarse_i))[*3] |-> rail3_step_mv_o == 12'(ctrl_o.rail3_voltage_code * (rail3_coarse_i ? 25 : 10)))
        else $error("step scale wrong");
endmodule
`default_nettype wire

// File: dv/rsmc_host.sv
/*
 Host model: single-byte register reads and writes.
 Assumes strobes are taken at the next rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module rsmc_host (
    input wire logic clk_i, // Clock
    input wire logic [7:0] rdata_i, // Read data
    output var rsmc_pkg::rsmc_req_type req_o // Request
);
    import rsmc_pkg::*;
    initial req_o = '0;
    // One-cycle write; callers keep bits 5:2 of control registers set
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) req_o <= '{1'b1, 1'b0, a, d};
        @(posedge clk_i) req_o <= '0;
    endtask
    // One-cycle read, data taken while it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) req_o <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_i) req_o <= '0;
        #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// File: dv/rsmc_regs_bench.sv
/*
 Testbench of the register slice with host model and checker.
 Assumes a factory image with sleep routed through pin A, moved to pin B mid-run.
*/
`timescale 1ns/10ps
`default_nettype none
module rsmc_regs_bench;
    import rsmc_pkg::*;
    logic clk_i = 0, srst_i = 1, sleep_pin_a = 0, sleep_pin_b = 0, coarse = 0;
    rsmc_req_type req;
    rsmc_otp_type otp = '{8'ha8, 8'h54, 8'hc1, 8'h02, 8'h03, 8'h01, 1'b1, 1'b0};
    logic [7:0] rdata, d;
    logic rvalid;
    rsmc_ctrl_type ctrl;
    logic [11:0] step;
    int bad_count = 0, n_checks = 0;
    always #12.5 clk_i = ~clk_i;
    rsmc_host h (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
    rsmc_regs uut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .otp_i(otp),
        .sleep_pin_a_i(sleep_pin_a), .sleep_pin_b_i(sleep_pin_b), .rail3_coarse_i(coarse),
        .rdata_o(rdata), .rvalid_o(rvalid), .ctrl_o(ctrl), .rail3_step_mv_o(step));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset images, fixed bits and unmapped read
    task automatic t_reset();
        h.rd(RSMC_OFS_RAIL3_VOLT, d);
        chk(d, 8'ha8);
        chk(rvalid, 1'b1);
        h.rd(RSMC_OFS_RAIL3_SLEEP, d);
        chk(d, 8'h54);
        h.rd(RSMC_OFS_RAIL4_CTRL, d);
        chk(d, 8'h3d);
        h.rd(8'h30, d);
        chk(d, 8'h00);
        chk(16'(ctrl), 16'({7'h54, 1'b0, 3'b110, 4'b1101}));
    endtask
    // Read-only bits and off controls of all four registers, mode controls of rails four to six
    task automatic t_ctrl();
        for (int i = 0; i < 4; i++) begin
            h.wr(RSMC_OFS_RAIL4_CTRL + 8'(i), 8'hff);
            h.rd(RSMC_OFS_RAIL4_CTRL + 8'(i), d);
            chk(d, 8'h3f);
        end
        chk(ctrl[7:0], 8'h7f);
        for (int i = 0; i < 4; i++)
            h.wr(RSMC_OFS_RAIL4_CTRL + 8'(i), 8'h3c);
        @(posedge clk_i);
        #1 chk(ctrl[7:0], 8'h00);
    endtask
    // Sleep gating, entry copy, scaling, no repeat copy, disable
    task automatic t_sleep();
        @(posedge clk_i) coarse <= 1'b1;
        h.wr(RSMC_OFS_RAIL3_SLEEP, 8'h67);
        sleep_pin_b <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl.rail3_in_sleep, 1'b0);
        @(posedge clk_i) sleep_pin_a <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl[14:7], 8'h67);
        chk(step, 12'(7'h33 * 25));
        h.wr(RSMC_OFS_RAIL3_SLEEP, 8'h21);
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl[14:8], 7'h33);
        h.rd(RSMC_OFS_RAIL3_VOLT, d);
        chk(d[7:1], 7'h33);
        h.wr(RSMC_OFS_RAIL3_SLEEP, 8'h20);
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl.rail3_in_sleep, 1'b0);
    endtask
    // Sleep through pin B once routing moves there; fine range scaling
    task automatic t_pin_b();
        @(posedge clk_i);
        otp.sleep_by_pin_a <= 1'b0;
        otp.sleep_by_pin_b <= 1'b1;
        sleep_pin_b <= 1'b0;
        coarse <= 1'b0;
        h.wr(RSMC_OFS_RAIL3_SLEEP, 8'h45);
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl.rail3_in_sleep, 1'b0);
        @(posedge clk_i);
        sleep_pin_b <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk(ctrl[14:7], 8'h45);
        chk(step, 12'(7'h22 * 10));
    endtask
    // Mid-run reset reloads the factory images over host writes
    task automatic t_rereset();
        @(posedge clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        h.rd(RSMC_OFS_RAIL3_SLEEP, d);
        chk(d, 8'h54);
        h.rd(RSMC_OFS_RAIL5_CTRL, d);
        chk(d, 8'h3e);
        chk(16'(ctrl), 16'({7'h54, 1'b0, 3'b110, 4'b1101}));
    endtask
    // Main sequence after ten reset cycles
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_ctrl();
        t_sleep();
        t_pin_b();
        t_rereset();
        stop_test();
    end
    // Watchdog well beyond the hundred or so cycles the tests need
    initial begin
        #50000;
        bad_count++;
        stop_test();
    end
endmodule
bind rsmc_regs rsmc_regs_monitor mon (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i),
    .otp_i(otp_i), .sleep_pin_a_i(sleep_pin_a_i), .sleep_pin_b_i(sleep_pin_b_i),
    .rail3_coarse_i(rail3_coarse_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .ctrl_o(ctrl_o), .rail3_step_mv_o(rail3_step_mv_o));
`default_nettype wire
